//--- inc/sfr_cfg.svh
/*
 sfr_cfg.svh: opcodes, status field positions, reset values and counts of the
 read and status-write command block.
 assumes: included by bare name; holds only macro definitions.
*/
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
`define SFR_CLK_PERIOD_NS 5
`define SFR_TW_NS 5000000
`define SFR_OP_WSR_LO 8'h01
`define SFR_OP_WSR_MID 8'h31
`define SFR_OP_WSR_HI 8'h11
`define SFR_OP_READ 8'h03
`define SFR_OP_FAST 8'h0B
`define SFR_OP_DOUT 8'h3B
`define SFR_OP_QOUT 8'h6B
`define SFR_OP_DIO 8'hBB
`define SFR_OP_QIO 8'hEB
`define SFR_OP_QWORD 8'hE7
`define SFR_OP_WRAP 8'h77
`define SFR_LANE_LO 24'h00_00FF
`define SFR_LANE_MID 24'h00_FF00
`define SFR_LANE_HI 24'hFF_0000
`define SFR_WSR_MASK 24'h60_7BFC
`define SFR_STATUS_RST 24'h00_0000
`define SFR_WRAP_RST 3'h1
`define SFR_BP_LSB 2
`define SFR_BP_MSB 6
`define SFR_SRP0 7
`define SFR_STATUS_PROTECT_BITS 8
`define SFR_QE 9
`define SFR_CONT_CODE 2'h2
`define SFR_OP_LAST 6'h07
`define SFR_ADDR_BITS 6'h18
`define SFR_BYTE_BITS 6'h08
`define SFR_WRAP_BITS 6'h20
`define SFR_WRAP_BASE 24'h00_0008
`define SFR_DUMMY_BYTE 4'h8
`define SFR_DUMMY_QIO 4'h4
`define SFR_DUMMY_QWORD 4'h2
`define SFR_ONE_HOT 24'h00_0001
`define SFR_OE_OFF 4'hF
`endif

//--- inc/sfr_pkg.sv
/*
 sfr_pkg: state and phase types of the read and status-write command block.
 assumes: nothing; only types.
*/
package sfr_pkg;
	typedef enum logic [2:0] {
		ST_CMD = 3'h0,
		ST_ADDR = 3'h1,
		ST_MODE = 3'h3,
		ST_DUMMY = 3'h2,
		ST_DATA = 3'h6,
		ST_WSR = 3'h7,
		ST_WRAP = 3'h5,
		ST_IGN = 3'h4
	} sfr_state_type;
	typedef enum logic [1:0] {
		LANE1 = 2'h0,
		LANE2 = 2'h1,
		LANE4 = 2'h2
	} sfr_lane_type;
	typedef struct packed {
		logic valid;
		logic quad;
		logic mode_en;
		logic wrap_ok;
		logic [3:0] dummy;
		sfr_lane_type in_lanes;
		sfr_lane_type out_lanes;
	} sfr_phase_type;
endpackage

//--- inc/sfr_mem_if.sv
/*
 sfr_mem_if: array port between the command logic and its byte memory.
 assumes: both ends on the same clock.
*/
interface sfr_mem_if #(parameter int AW = 10) ();
	logic [AW-1:0] rd_addr;
	logic [7:0] rd_data;
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [7:0] wr_data;
	modport ctl (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

//--- rtl/sfr_mem.sv
/*
 sfr_mem: byte array standing in for the flash cells, registered read data.
 assumes: loaded over its write port by the rest of the device.
*/
module sfr_mem #(
	parameter int AW = 10
) (
	input wire logic clk_i,
	sfr_mem_if.mem port
);
	logic [7:0] store [0:(1<<AW)-1];

	always_ff @(posedge clk_i) begin
		if (port.wr_en) begin
			store[port.wr_addr] <= port.wr_data;
		end
	end

	// read data one clock after the address; the read path hides it
	always_ff @(posedge clk_i) begin
		port.rd_data <= store[port.rd_addr];
	end
endmodule

//--- rtl/sfr_read_wsr.sv
/*
 sfr_read_wsr: serial flash command slice for status write, the read family,
 continuous read mode and burst wrap, with the byte array below it.
 assumes: host pins are asynchronous and sclk is far slower than mclk_i
 (at least eight mclk_i periods per sclk period).
*/
// Notes on behaviour
// - status write needs write enable latch set
// - status write keeps the fixed status bits
// - status write needs exactly eight data bits
// - chip select rise starts timed status write
// - busy flag high during status write cycle
// - write enable latch cleared at cycle end
// - status write updates protect bits, pin permitting
// - hardware protected mode ignores status write
// - plain read: address in, serial data out
// - address increments after every output byte
// - reads rejected at the opcode while a cycle runs; continuous mode skips this check
// - fast read adds one dummy byte
// - dual output read drives two lines
// - quad output read drives four lines
// - dual io read: two-line address, data
// - dual io continuous mode skips the opcode
// - quad io read: four-line address, dummies
// - quad io continuous mode skips the opcode
// - wrap confines quad io reads in page
// - wrap bit W4 enables, W6-W5 length
// - quad word read uses two dummy clocks
// - wrap set by 77H, persists until changed
// - W4 low enables 8/16/32/64 byte wrap
`include "sfr_cfg.svh"
module sfr_read_wsr #(
	parameter int MEM_AW = 10,
	parameter int TW_NS = `SFR_TW_NS
) (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic [3:0] io_i,
	output logic [3:0] io_o,
	output logic [3:0] io_oe_n_o,
	input wire logic wp_n_i,
	input wire logic write_enable_latch_i,
	input wire logic array_busy_i,
	input wire logic load_en_i,
	input wire logic [MEM_AW-1:0] load_addr_i,
	input wire logic [7:0] load_data_i,
	output logic busy_flag_o,
	output logic wel_clear_o,
	output logic [23:0] status_o,
	output logic [4:0] block_protect_bits_o,
	output logic [1:0] status_protect_bits_o,
	output logic quad_enable_bit_o,
	output logic [2:0] wrap_setting_bits_o
);
	localparam int TW_CYC = (TW_NS / `SFR_CLK_PERIOD_NS) > 0 ? TW_NS / `SFR_CLK_PERIOD_NS : 1;
	localparam logic [31:0] TW_LAST = 32'(TW_CYC - 1);

	logic [6:0] pin_s1_reg, pin_s2_reg;
	logic sclk_d_reg, cs_d_reg;
	sfr_pkg::sfr_state_type state_reg, dec_state;
	logic [5:0] cnt_reg;
	logic [7:0] cmd_reg;
	logic [31:0] sh_reg, sh_next;
	logic [23:0] addr_reg, status_reg, pend_data_reg, pend_mask_reg;
	logic cont_reg, wsr_busy_reg, wel_clear_reg;
	logic [31:0] tw_cnt_reg;
	logic [2:0] wrap_reg;
	logic [7:0] out_sh_reg, cur_byte;
	logic [3:0] bits_left_reg, io_reg, oe_n_reg, lane_n;
	logic [3:0] io_s;
	logic sclk_s, cs_s, wp_s, sclk_rise, sclk_fall, cs_rise;
	logic cmd_done, busy_any, hw_prot, data_load, wrap_on, wsr_ok;
	sfr_pkg::sfr_phase_type ph, ph_new;
	sfr_pkg::sfr_lane_type in_lanes;

	sfr_mem_if #(.AW(MEM_AW)) mif ();

	sfr_mem #(.AW(MEM_AW)) u_mem (
		.clk_i(mclk_i),
		.port(mif.mem)
	);

	function automatic sfr_pkg::sfr_phase_type phase_of(input logic [7:0] op);
		sfr_pkg::sfr_phase_type p;
		p = '0;
		p.valid = 1'b1;
		case (op)
			`SFR_OP_READ: p.valid = 1'b1;
			`SFR_OP_FAST: p.dummy = `SFR_DUMMY_BYTE;
			`SFR_OP_DOUT: begin
				p.dummy = `SFR_DUMMY_BYTE;
				p.out_lanes = sfr_pkg::LANE2;
			end
			`SFR_OP_QOUT: begin
				p.dummy = `SFR_DUMMY_BYTE;
				p.out_lanes = sfr_pkg::LANE4;
				p.quad = 1'b1;
			end
			`SFR_OP_DIO: begin
				p.in_lanes = sfr_pkg::LANE2;
				p.out_lanes = sfr_pkg::LANE2;
				p.mode_en = 1'b1;
			end
			`SFR_OP_QIO, `SFR_OP_QWORD: begin
				p.in_lanes = sfr_pkg::LANE4;
				p.out_lanes = sfr_pkg::LANE4;
				p.mode_en = 1'b1;
				p.quad = 1'b1;
				p.wrap_ok = 1'b1;
				p.dummy = (op == `SFR_OP_QIO) ? `SFR_DUMMY_QIO : `SFR_DUMMY_QWORD;
			end
			default: p.valid = 1'b0;
		endcase
		return p;
	endfunction

	function automatic logic is_wsr(input logic [7:0] op);
		return op == `SFR_OP_WSR_LO || op == `SFR_OP_WSR_MID || op == `SFR_OP_WSR_HI;
	endfunction

	function automatic logic [5:0] last_clk(input logic [5:0] bits, input sfr_pkg::sfr_lane_type l);
		return (bits >> l) - 6'h01;
	endfunction

	function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap,
			input logic [1:0] len);
		logic [23:0] m;
		logic [23:0] inc;
		m = (`SFR_WRAP_BASE << len) - `SFR_ONE_HOT;
		inc = a + `SFR_ONE_HOT;
		return wrap ? ((a & ~m) | (inc & m)) : inc;
	endfunction

	// two flops on every pin; edges are found on the second stage only
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			// sclk stages reset to its idle low level, so no false edge follows reset
			pin_s1_reg <= 7'h6F;
			pin_s2_reg <= 7'h6F;
			sclk_d_reg <= 1'b0;
			cs_d_reg <= 1'b1;
		end else begin
			pin_s1_reg <= {wp_n_i, cs_n_i, sclk_i, io_i};
			pin_s2_reg <= pin_s1_reg;
			sclk_d_reg <= pin_s2_reg[4];
			cs_d_reg <= pin_s2_reg[5];
		end
	end

	assign io_s = pin_s2_reg[3:0];
	assign sclk_s = pin_s2_reg[4];
	assign cs_s = pin_s2_reg[5];
	assign wp_s = pin_s2_reg[6];
	assign sclk_rise = !cs_s && sclk_s && !sclk_d_reg;
	assign sclk_fall = !cs_s && !sclk_s && sclk_d_reg;
	assign cs_rise = cs_s && !cs_d_reg;

	assign ph = phase_of(cmd_reg);
	assign ph_new = phase_of(sh_next[7:0]);
	assign busy_any = wsr_busy_reg || array_busy_i;
	assign hw_prot = status_reg[`SFR_STATUS_PROTECT_BITS] || (status_reg[`SFR_SRP0] && !wp_s);
	assign cmd_done = sclk_rise && state_reg == sfr_pkg::ST_CMD && cnt_reg == `SFR_OP_LAST;
	assign data_load = sclk_fall && state_reg == sfr_pkg::ST_DATA && bits_left_reg == 4'h0;
	assign wrap_on = ph.wrap_ok && !wrap_reg[0];
	assign wsr_ok = write_enable_latch_i && !busy_any && !hw_prot;

	always_comb begin
		unique case (state_reg)
			sfr_pkg::ST_ADDR, sfr_pkg::ST_MODE: in_lanes = ph.in_lanes;
			sfr_pkg::ST_WRAP: in_lanes = sfr_pkg::LANE4;
			default: in_lanes = sfr_pkg::LANE1;
		endcase
		unique case (in_lanes)
			sfr_pkg::LANE2: sh_next = {sh_reg[29:0], io_s[1:0]};
			sfr_pkg::LANE4: sh_next = {sh_reg[27:0], io_s};
			default: sh_next = {sh_reg[30:0], io_s[0]};
		endcase
	end

	always_comb begin
		if (is_wsr(sh_next[7:0])) begin
			dec_state = wsr_ok ? sfr_pkg::ST_WSR : sfr_pkg::ST_IGN;
		end else if (sh_next[7:0] == `SFR_OP_WRAP) begin
			dec_state = sfr_pkg::ST_WRAP;
		end else if (!ph_new.valid || busy_any || (ph_new.quad && !status_reg[`SFR_QE])) begin
			dec_state = sfr_pkg::ST_IGN;
		end else begin
			dec_state = sfr_pkg::ST_ADDR;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= sfr_pkg::ST_CMD;
			cnt_reg <= 6'h00;
			cmd_reg <= 8'h00;
			sh_reg <= 32'h0000_0000;
			addr_reg <= 24'h00_0000;
			cont_reg <= 1'b0;
		end else if (cs_s) begin
			state_reg <= cont_reg ? sfr_pkg::ST_ADDR : sfr_pkg::ST_CMD;
			cnt_reg <= 6'h00;
		end else if (sclk_rise) begin
			sh_reg <= sh_next;
			cnt_reg <= cnt_reg + 6'h01;
			unique case (state_reg)
				sfr_pkg::ST_CMD: if (cnt_reg == `SFR_OP_LAST) begin
					cnt_reg <= 6'h00;
					cmd_reg <= sh_next[7:0];
					state_reg <= dec_state;
				end
				sfr_pkg::ST_ADDR: if (cnt_reg == last_clk(`SFR_ADDR_BITS, ph.in_lanes)) begin
					cnt_reg <= 6'h00;
					addr_reg <= sh_next[23:0];
					state_reg <= ph.mode_en ? sfr_pkg::ST_MODE :
						(ph.dummy != 4'h0 ? sfr_pkg::ST_DUMMY : sfr_pkg::ST_DATA);
				end
				sfr_pkg::ST_MODE: if (cnt_reg == last_clk(`SFR_BYTE_BITS, ph.in_lanes)) begin
					cnt_reg <= 6'h00;
					cont_reg <= sh_next[5:4] == `SFR_CONT_CODE;
					state_reg <= ph.dummy != 4'h0 ? sfr_pkg::ST_DUMMY : sfr_pkg::ST_DATA;
				end
				sfr_pkg::ST_DUMMY: if (cnt_reg == {2'b00, ph.dummy - 4'h1}) begin
					state_reg <= sfr_pkg::ST_DATA;
				end
				sfr_pkg::ST_WSR: if (cnt_reg > `SFR_BYTE_BITS) begin
					cnt_reg <= cnt_reg; // saturate: any count past eight is a discard
				end
				sfr_pkg::ST_WRAP: if (cnt_reg == last_clk(`SFR_WRAP_BITS, sfr_pkg::LANE4)) begin
					state_reg <= sfr_pkg::ST_IGN;
				end
				sfr_pkg::ST_DATA, sfr_pkg::ST_IGN: cnt_reg <= 6'h00;
			endcase
		end else if (data_load) begin
			addr_reg <= next_addr(addr_reg, wrap_on, wrap_reg[2:1]);
		end
	end

	// wrap setting lives across commands until the next 77H
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wrap_reg <= `SFR_WRAP_RST;
		end else if (sclk_rise && state_reg == sfr_pkg::ST_WRAP &&
				cnt_reg == last_clk(`SFR_WRAP_BITS, sfr_pkg::LANE4)) begin
			wrap_reg <= sh_next[6:4];
		end
	end

	// status write: staged at chip select rise, committed when the cycle ends
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			status_reg <= `SFR_STATUS_RST;
			pend_data_reg <= 24'h00_0000;
			pend_mask_reg <= 24'h00_0000;
			wsr_busy_reg <= 1'b0;
			tw_cnt_reg <= 32'h0000_0000;
			wel_clear_reg <= 1'b0;
		end else begin
			wel_clear_reg <= 1'b0;
			if (cs_rise && state_reg == sfr_pkg::ST_WSR && cnt_reg == `SFR_BYTE_BITS) begin
				wsr_busy_reg <= 1'b1;
				tw_cnt_reg <= TW_LAST;
				pend_data_reg <= {3{sh_reg[7:0]}};
				pend_mask_reg <= `SFR_WSR_MASK & (cmd_reg == `SFR_OP_WSR_LO ? `SFR_LANE_LO :
					cmd_reg == `SFR_OP_WSR_MID ? `SFR_LANE_MID : `SFR_LANE_HI);
			end else if (wsr_busy_reg) begin
				if (tw_cnt_reg == 32'h0000_0000) begin
					wsr_busy_reg <= 1'b0;
					wel_clear_reg <= 1'b1;
					status_reg <= (status_reg & ~pend_mask_reg) |
						(pend_data_reg & pend_mask_reg);
				end else begin
					tw_cnt_reg <= tw_cnt_reg - 32'h0000_0001;
				end
			end
		end
	end

	// output bytes are taken from the array on the falling edge that sends their first bits
	assign cur_byte = (bits_left_reg == 4'h0) ? mif.rd_data : out_sh_reg;
	assign lane_n = 4'h1 << ph.out_lanes;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			io_reg <= 4'h0;
			oe_n_reg <= `SFR_OE_OFF;
			out_sh_reg <= 8'h00;
			bits_left_reg <= 4'h0;
		end else if (cs_s) begin
			oe_n_reg <= `SFR_OE_OFF;
			bits_left_reg <= 4'h0;
		end else if (sclk_fall && state_reg == sfr_pkg::ST_DATA) begin
			out_sh_reg <= cur_byte << lane_n;
			bits_left_reg <= (bits_left_reg == 4'h0 ? 4'h8 : bits_left_reg) - lane_n;
			unique case (ph.out_lanes)
				sfr_pkg::LANE2: begin
					io_reg <= {2'b00, cur_byte[7:6]};
					oe_n_reg <= 4'hC;
				end
				sfr_pkg::LANE4: begin
					io_reg <= cur_byte[7:4];
					oe_n_reg <= 4'h0;
				end
				default: begin
					io_reg <= {2'b00, cur_byte[7], 1'b0};
					oe_n_reg <= 4'hD;
				end
			endcase
		end
	end

	assign mif.rd_addr = addr_reg[MEM_AW-1:0];
	assign mif.wr_en = load_en_i;
	assign mif.wr_addr = load_addr_i;
	assign mif.wr_data = load_data_i;

	assign io_o = io_reg;
	assign io_oe_n_o = oe_n_reg;
	assign busy_flag_o = wsr_busy_reg;
	assign wel_clear_o = wel_clear_reg;
	assign status_o = status_reg;
	assign block_protect_bits_o = status_reg[`SFR_BP_MSB:`SFR_BP_LSB];
	assign status_protect_bits_o = {status_reg[`SFR_STATUS_PROTECT_BITS], status_reg[`SFR_SRP0]};
	assign quad_enable_bit_o = status_reg[`SFR_QE];
	assign wrap_setting_bits_o = wrap_reg;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	a_wsr_needs_wel: assert property (
		cmd_done && is_wsr(sh_next[7:0]) && !write_enable_latch_i |=> state_reg == sfr_pkg::ST_IGN)
		else $error("status write taken without write enable");
	a_fixed_bits_kept: assert property (
		((status_reg ^ $past(status_reg)) & ~`SFR_WSR_MASK) == 24'h00_0000)
		else $error("fixed status bit changed");
	a_short_wsr_dropped: assert property (
		cs_rise && state_reg == sfr_pkg::ST_WSR && cnt_reg != `SFR_BYTE_BITS && !wsr_busy_reg
		|=> !wsr_busy_reg [*2])
		else $error("status write started without exactly eight bits");
	a_wsr_cycle_start: assert property (
		cs_rise && state_reg == sfr_pkg::ST_WSR && cnt_reg == `SFR_BYTE_BITS
		|=> wsr_busy_reg && tw_cnt_reg == TW_LAST)
		else $error("status write cycle did not start");
	a_busy_holds: assert property (
		wsr_busy_reg && tw_cnt_reg != 32'h0000_0000 |=> wsr_busy_reg && $stable(status_reg))
		else $error("busy dropped before the write time");
	a_wel_clear_end: assert property (
		$fell(wsr_busy_reg) |-> wel_clear_o ##1 !wel_clear_o)
		else $error("write enable latch not cleared at cycle end");
	a_hw_protect: assert property (
		cmd_done && is_wsr(sh_next[7:0]) && hw_prot |=> state_reg == sfr_pkg::ST_IGN)
		else $error("status write accepted while protected");
	a_read_rejected: assert property (
		cmd_done && sh_next[7:0] == `SFR_OP_READ && busy_any |=> state_reg == sfr_pkg::ST_IGN)
		else $error("read accepted during a cycle");
	a_quad_gated: assert property (
		cmd_done && ph_new.quad && !status_reg[`SFR_QE] |=> state_reg == sfr_pkg::ST_IGN)
		else $error("quad read accepted without quad enable");
	a_lines_released: assert property (
		cs_s |=> io_oe_n_o == `SFR_OE_OFF)
		else $error("data lines driven with chip select high");
	a_cont_skip: assert property (
		cs_s && cont_reg |=> state_reg == sfr_pkg::ST_ADDR)
		else $error("continuous mode did not skip the opcode");
	a_addr_step: assert property (
		data_load |=> addr_reg == next_addr($past(addr_reg), $past(wrap_on), $past(wrap_reg[2:1])))
		else $error("address not stepped after a byte");

	c_wsr_cycle: cover property ($fell(wsr_busy_reg));
	c_quad_data: cover property (data_load && ph.out_lanes == sfr_pkg::LANE4);
	c_wrap_read: cover property (data_load && wrap_on);
	c_cont_entry: cover property (cs_s && cont_reg ##1 !cs_s);
endmodule

//--- dv/sfr_host_model.sv
/*
 sfr_host_model: host controller driving chip select, serial clock and data lines.
 assumes: the bench resolves each line from the device output enables and feeds it to io_w_i.
*/
module sfr_host_model (
	output logic cs_n_o,
	output logic sclk_o,
	output logic [3:0] io_h_o,
	input wire logic [3:0] io_w_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rx;
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		io_h_o = 4'h0;
		rx = 32'h0000_0000;
	end
	task automatic go();
		cs_n_o = 1'b0;
		#24;
	endtask
	// n clocks of w lanes, msb first; a released line shows the inverse level
	task automatic sh(input int n, input int w, input logic [31:0] d, input bit drv);
		for (int k = 0; k < n; k++) begin
			io_h_o = drv ? 4'(d[31:28] >> (4 - w)) : ~io_h_o;
			d = d << w;
			#24 sclk_o = 1'b1;
			rx = (rx << w) | (w == 1 ? 32'(io_w_i[1]) : 32'(io_w_i & 4'(4'hF >> (4 - w))));
			#24 sclk_o = 1'b0;
		end
	endtask
	// clock stands low between frames
	task automatic fin();
		#24 cs_n_o = 1'b1;
		#300;
	endtask
endmodule

//--- dv/sfr_read_wsr_tb.sv
/*
 sfr_read_wsr_tb: self-checking bench of the status write and read family.
 assumes: sfr_host_model plays the host; the bench keeps an array and status model.
*/
`include "sfr_cfg.svh"
module sfr_read_wsr_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TW = 4000;
	localparam logic [7:0] OPS [7] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'hE7};
	localparam int WI [7] = '{1, 1, 1, 1, 2, 4, 4};
	localparam int WO [7] = '{1, 1, 2, 4, 2, 4, 4};
	localparam int DC [7] = '{0, 8, 8, 8, 0, 4, 2};
	localparam bit MD [7] = '{0, 0, 0, 0, 1, 1, 1};
	logic mclk, resetn, cs_n, sclk, wp_n, write_enable_latch, abusy, load_en, busy, wclr, qe, drove;
	logic [3:0] io_h, io_w, io_o, io_oe_n;
	logic [9:0] load_addr;
	logic [7:0] load_data;
	logic [23:0] status, st, a;
	logic [4:0] bp;
	logic [1:0] srp;
	logic [2:0] wrap, wset;
	logic [7:0] mem [1024];
	int num_errors = 0;
	int total_checks = 0;
	int seed = 81752;
	int bcnt = 0;
	int ccnt = 0;
	assign io_w = (~io_oe_n & io_o) | (io_oe_n & io_h);
	sfr_host_model i_sfr_host_model (.cs_n_o(cs_n), .sclk_o(sclk), .io_h_o(io_h), .io_w_i(io_w));
	sfr_read_wsr #(.MEM_AW(10), .TW_NS(TW)) i_sfr_read_wsr (.mclk_i(mclk), .resetn_i(resetn),
		.cs_n_i(cs_n), .sclk_i(sclk), .io_i(io_w), .io_o(io_o), .io_oe_n_o(io_oe_n),
		.wp_n_i(wp_n), .write_enable_latch_i(write_enable_latch), .array_busy_i(abusy), .load_en_i(load_en),
		.load_addr_i(load_addr), .load_data_i(load_data), .busy_flag_o(busy),
		.wel_clear_o(wclr), .status_o(status), .block_protect_bits_o(bp),
		.status_protect_bits_o(srp), .quad_enable_bit_o(qe), .wrap_setting_bits_o(wrap));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		bcnt <= bcnt + int'(busy === 1'b1);
		ccnt <= ccnt + int'(wclr === 1'b1);
		if (io_oe_n !== 4'hF) drove <= 1'b1;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// fractional offset keeps host edges off the mclk edges
	task automatic rd(input int j, input logic [23:0] ad, input logic [7:0] m, input bit skip,
			input bit ok);
		logic [31:0] e;
		logic [23:0] p;
		int sz;
		e = 32'h0;
		p = ad;
		sz = 8 << wset[2:1];
		for (int k = 0; k < 4; k++) begin
			e = {e[23:0], mem[p[9:0]]};
			if (j > 4 && !wset[0]) p = (p & ~24'(sz - 1)) | ((p + 24'h1) & 24'(sz - 1));
			else p = p + 24'h1;
		end
		@(posedge mclk);
		#1.25 drove = 1'b0;
		i_sfr_host_model.go();
		if (!skip) i_sfr_host_model.sh(8, 1, {OPS[j], 24'h0}, 1'b1);
		i_sfr_host_model.sh(24 / WI[j], WI[j], {ad, 8'h0}, 1'b1);
		if (MD[j]) i_sfr_host_model.sh(8 / WI[j], WI[j], {m, 24'h0}, 1'b1);
		i_sfr_host_model.sh(DC[j], WI[j], 32'h0, 1'b0);
		i_sfr_host_model.sh(32 / WO[j], WO[j], 32'h0, 1'b0);
		i_sfr_host_model.fin();
		check("oe released", 32'(io_oe_n), 32'hF);
		check("lines driven", 32'(drove), 32'(ok));
		if (ok) check("read data", i_sfr_host_model.rx, e);
	endtask
	task automatic wsr(input logic [7:0] op, input logic [7:0] d, input int nb, input bit ok,
			input bit probe);
		int s;
		@(posedge mclk);
		#1.25 bcnt = 0;
		ccnt = 0;
		i_sfr_host_model.go();
		i_sfr_host_model.sh(8, 1, {op, 24'h0}, 1'b1);
		i_sfr_host_model.sh(nb, 1, {d, 24'h0}, 1'b1);
		i_sfr_host_model.fin();
		s = op == 8'h01 ? 0 : (op == 8'h31 ? 8 : 16);
		if (ok) st = (st & ~(`SFR_WSR_MASK & (24'hFF << s))) | ((24'(d) << s) & `SFR_WSR_MASK);
		if (probe) rd(0, 24'h12, 8'h00, 1'b0, 1'b0);
		for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(posedge mclk);
		repeat (4) @(posedge mclk);
		check("busy cycles", bcnt, ok ? TW / 5 : 0);
		check("latch clear", ccnt, 32'(ok));
		check("status", status, st);
		check("fields", {qe, srp, bp}, {st[9], st[8:7], st[6:2]});
	endtask
	task automatic wrap_set(input logic [2:0] w);
		@(posedge mclk);
		#1.25 i_sfr_host_model.go();
		i_sfr_host_model.sh(8, 1, {8'h77, 24'h0}, 1'b1);
		i_sfr_host_model.sh(8, 4, {25'h0, w, 4'h0}, 1'b1);
		i_sfr_host_model.fin();
		wset = w;
		check("wrap bits", wrap, w);
	endtask
	initial begin
		#400000;
		num_errors++;
		wrap_up();
	end
	initial begin
		resetn = 1'b0;
		{wp_n, write_enable_latch, abusy, load_en, load_addr, load_data} = {1'b1, 21'h0};
		st = 24'h0;
		wset = 3'h1;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		repeat (8) @(posedge mclk);
		check("reset", {busy, wclr, io_oe_n, status}, 32'h0F00_0000);
		check("wrap reset", wrap, 3'h1);
		for (int k = 0; k < 1024; k++) begin
			mem[k] = 8'($random(seed));
			@(posedge mclk);
			load_en <= 1'b1;
			load_addr <= 10'(k);
			load_data <= mem[k];
		end
		@(posedge mclk);
		load_en <= 1'b0;
		wsr(8'h01, 8'hFF, 8, 1'b0, 1'b0);
		@(posedge mclk);
		write_enable_latch <= 1'b1;
		wsr(8'h31, 8'h02, 7, 1'b0, 1'b0);
		wsr(8'h31, (8'($random(seed)) & 8'hFE) | 8'h02, 8, 1'b1, 1'b1);
		wsr(8'h01, 8'($random(seed)) & 8'h7F, 8, 1'b1, 1'b0);
		wsr(8'h11, 8'hFF, 8, 1'b1, 1'b0);
		wsr(8'h01, 8'h80, 8, 1'b1, 1'b0);
		@(posedge mclk);
		wp_n <= 1'b0;
		wsr(8'h01, 8'h00, 8, 1'b0, 1'b0);
		@(posedge mclk);
		wp_n <= 1'b1;
		wsr(8'h01, 8'h00, 8, 1'b1, 1'b0);
		for (int k = 0; k < 28; k++) begin
			a = 24'($random(seed)) & ~24'(k % 7 == 6);
			rd(k % 7, a, 8'h00, 1'b0, 1'b1);
		end
		@(posedge mclk);
		abusy <= 1'b1;
		rd(1, a, 8'h00, 1'b0, 1'b0);
		@(posedge mclk);
		abusy <= 1'b0;
		for (int j = 4; j < 7; j++) begin
			rd(j, a, 8'h20, 1'b0, 1'b1);
			rd(j, a + 24'h40, 8'h00, 1'b1, 1'b1);
		end
		for (int w = 0; w < 8; w++) begin
			wrap_set(3'(w));
			rd(5 + w % 2, {18'($random(seed)), 6'h3E}, 8'h00, 1'b0, 1'b1);
		end
		wsr(8'h31, 8'h00, 8, 1'b1, 1'b0);
		for (int j = 3; j < 7; j++) begin
			if (j != 4) rd(j, a, 8'h00, 1'b0, 1'b0);
		end
		wrap_up();
	end
endmodule
